// [shared/spi_sdm_pkg.sv]
// Purpose: constants for the serial status, data and match block
// Assumes: 100 MHz clk, 8-bit registers on a plain strobe port
// Notes: link runs in one clock format, msb first
package spi_sdm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_DATA = 4'h5;
  localparam logic [3:0] ADDR_COMPARE = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
  // status bits
  localparam int BIT_RXFULL = 7;
  localparam int BIT_MATCH = 6;
  localparam int BIT_TXEMPTY = 5;
  localparam int BIT_FAULT = 4;
  // first control register bits
  localparam int C1_IRQ_EN = 7;
  localparam int C1_MASTER = 4;
  localparam int C1_SELECT_OUTPUT_ENABLE = 1;
  // second control register bits
  localparam int C2_MATCH_IRQ = 7;
  localparam int C2_FAULT_EN = 4;
  // sticky event bits
  localparam int EV_RXFULL = 0;
  localparam int EV_MATCH = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_OVERRUN = 3;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] EVENT_RST = 4'h0;
  // synchroniser order {select, mosi, miso, sclk}; select idles high
  localparam logic [3:0] SYNC_RST = 4'h8;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 40;
  localparam int HALF_RAW = SCLK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SCLK_HALF_CYCLES =
    8'((HALF_RAW < 1) ? 1 : HALF_RAW);
  localparam logic [3:0] LAST_BIT = 4'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} link_state_t;
endpackage

// [rtl/spi_status_data_match.sv]
// Purpose: status flags, data buffers and match compare of a byte serial port
// Assumes: link pins arrive asynchronous and pass two flops first
// Notes: clock format fixed at idle-low, sample on rise, msb first
`timescale 1ns/1ps
`default_nettype none
module spi_status_data_match import spi_sdm_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset
  input wire logic [3:0] addr, // register address
  input wire logic [7:0] wrData, // write data
  input wire logic wrStrobe, // write strobe
  input wire logic rdStrobe, // read strobe
  output logic [7:0] rdData, // read data, cycle after strobe
  output logic irq, // interrupt level
  input wire logic sclkIn, // serial clock pin in
  output logic sclkOut, // serial clock pin out
  output logic sclkOeN, // serial clock drive, low drives
  input wire logic mosiIn, // master-out pin in
  output logic mosiOut, // master-out pin out
  output logic mosiOeN, // master-out drive, low drives
  input wire logic misoIn, // master-in pin in
  output logic misoOut, // master-in pin out
  output logic misoOeN, // master-in drive, low drives
  input wire logic ssIn, // select pin in, active low
  output logic ssOut, // select pin out, active low
  output logic ssOeN // select drive, low drives
);
  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [3:0] syncA, syncB, syncC;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA <= SYNC_RST;
      syncB <= SYNC_RST;
      syncC <= SYNC_RST;
    end else begin
      syncA <= {ssIn, mosiIn, misoIn, sclkIn};
      syncB <= syncA;
      syncC <= syncB;
    end
  end
  logic sclkRise, sclkFall, ssLow, ssFell;
  assign sclkRise = syncB[0] & ~syncC[0];
  assign sclkFall = ~syncB[0] & syncC[0];
  assign ssLow = ~syncB[3];
  assign ssFell = ~syncB[3] & syncC[3];

  // ****************************************************
  // state
  // ****************************************************
  logic [7:0] ctrl1, ctrl2, compare, rxBuf, txBuf, shifter;
  logic [3:0] irqStat, irqMask, bitCnt;
  logic txFull, rxFull, matchFlag, faultFlag, cmpPending, latchBit;
  logic armTx, armRx, armMatch, armFault, sclkReg;
  logic [7:0] divCnt;
  link_state_t state;
  logic [7:0] next_ctrl1, next_ctrl2, next_compare, next_rxBuf;
  logic [7:0] next_txBuf, next_shifter, next_rdData, next_divCnt;
  logic [3:0] next_irqStat, next_irqMask, next_bitCnt;
  logic next_txFull, next_rxFull, next_matchFlag, next_faultFlag;
  logic next_cmpPending, next_latchBit, next_sclkReg;
  logic next_armTx, next_armRx, next_armMatch, next_armFault;
  link_state_t next_state;
  logic master, faultEn, select_output_enable, done, faultHit;
  logic wrCtrl1, wrStatus, wrDataPort, rdStatus, rdDataPort;
  logic accept, loadShift;
  logic [7:0] doneByte, statusValue;
  logic [3:0] events;

  assign master = ctrl1[C1_MASTER];
  assign faultEn = ctrl2[C2_FAULT_EN];
  assign select_output_enable = ctrl1[C1_SELECT_OUTPUT_ENABLE];
  assign wrCtrl1 = wrStrobe && addr == ADDR_CTRL1;
  assign wrStatus = wrStrobe && addr == ADDR_STATUS;
  assign wrDataPort = wrStrobe && addr == ADDR_DATA;
  assign rdStatus = rdStrobe && addr == ADDR_STATUS;
  assign rdDataPort = rdStrobe && addr == ADDR_DATA;
  assign accept = wrDataPort && armTx;
  // low nibble unimplemented, transmit-empty is the buffer's emptiness
  assign statusValue = {rxFull, matchFlag, ~txFull, faultFlag, 4'h0};
  assign faultHit = master && faultEn && !select_output_enable && ssFell;

  // ****************************************************
  // next-value logic
  // ****************************************************
  always_comb begin
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_compare = compare;
    next_rxBuf = rxBuf;
    next_txBuf = txBuf;
    next_shifter = shifter;
    next_irqStat = irqStat;
    next_irqMask = irqMask;
    next_bitCnt = bitCnt;
    next_txFull = txFull;
    next_rxFull = rxFull;
    next_matchFlag = matchFlag;
    next_faultFlag = faultFlag;
    next_cmpPending = 1'b0;
    next_latchBit = latchBit;
    next_sclkReg = sclkReg;
    next_armTx = armTx;
    next_armRx = armRx;
    next_armMatch = armMatch;
    next_armFault = armFault;
    next_divCnt = divCnt;
    next_state = state;
    next_rdData = 8'h00;
    done = 1'b0;
    loadShift = 1'b0;
    doneByte = {shifter[6:0], latchBit};
    events = 4'h0;
    // software writes; the status register keeps nothing
    if (wrCtrl1) begin
      next_ctrl1 = wrData;
    end
    if (wrStrobe && addr == ADDR_CTRL2) begin
      next_ctrl2 = wrData;
    end
    if (wrStrobe && addr == ADDR_COMPARE) begin
      next_compare = wrData;
    end
    if (wrStrobe && addr == ADDR_IRQ_MASK) begin
      next_irqMask = wrData[3:0];
    end
    if (wrStrobe && addr == ADDR_IRQ_STAT) begin
      next_irqStat = irqStat & ~wrData[3:0];
    end
    // read mux, zero for unmapped
    if (rdStrobe) begin
      case (addr)
        ADDR_CTRL1: next_rdData = ctrl1;
        ADDR_CTRL2: next_rdData = ctrl2;
        ADDR_STATUS: next_rdData = statusValue;
        ADDR_DATA: next_rdData = rxBuf;
        ADDR_COMPARE: next_rdData = compare;
        ADDR_IRQ_STAT: next_rdData = {4'h0, irqStat};
        ADDR_IRQ_MASK: next_rdData = {4'h0, irqMask};
        default: next_rdData = 8'h00;
      endcase
    end
    // two-step clears: arm on status read, act on the second access
    if (rdDataPort && armRx) begin
      next_rxFull = 1'b0;
      next_armRx = 1'b0;
    end
    if (wrStatus && wrData[BIT_MATCH] && armMatch) begin
      next_matchFlag = 1'b0;
      next_armMatch = 1'b0;
    end
    if (wrCtrl1 && armFault) begin
      next_faultFlag = 1'b0;
      next_armFault = 1'b0;
    end
    if (rdStatus) begin
      next_armTx = armTx | ~txFull;
      next_armRx = armRx | rxFull;
      next_armMatch = armMatch | matchFlag;
      next_armFault = armFault | faultFlag;
    end
    // link engine
    case (state)
      ST_IDLE: begin
        next_sclkReg = 1'b0;
        if (master) begin
          next_bitCnt = 4'h0;
          if (txFull) begin
            loadShift = 1'b1;
            next_state = ST_LEAD;
            next_divCnt = 8'h00;
          end
        end else if (!ssLow) begin
          // deselected slave is forced idle
          next_bitCnt = 4'h0;
          loadShift = txFull;
        end else begin
          loadShift = txFull && bitCnt == 4'h0 && !sclkRise;
          if (sclkRise) begin
            next_latchBit = syncB[2];
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == LAST_BIT) begin
              done = 1'b1;
              doneByte = {shifter[6:0], syncB[2]};
              next_bitCnt = 4'h0;
            end
          end
          if (sclkFall && bitCnt != 4'h0) begin
            next_shifter = {shifter[6:0], latchBit};
          end
        end
      end
      ST_LEAD: begin
        next_divCnt = divCnt + 8'h01;
        if (divCnt == SCLK_HALF_CYCLES - 8'h01) begin
          next_divCnt = 8'h00;
          next_state = ST_SHIFT;
          next_sclkReg = 1'b1;
          next_latchBit = syncB[1];
        end
      end
      ST_SHIFT: begin
        next_divCnt = divCnt + 8'h01;
        if (divCnt == SCLK_HALF_CYCLES - 8'h01) begin
          next_divCnt = 8'h00;
          next_sclkReg = ~sclkReg;
          if (!sclkReg) begin
            next_latchBit = syncB[1];
          end else begin
            next_shifter = {shifter[6:0], latchBit};
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == LAST_BIT) begin
              done = 1'b1;
              next_bitCnt = 4'h0;
              next_state = ST_IDLE; // queued byte loads next
            end
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (loadShift) begin
      next_shifter = txBuf;
      next_txFull = 1'b0;
    end
    if (accept) begin
      next_txBuf = wrData;
      next_txFull = 1'b1;
      next_armTx = 1'b0;
    end
    // completion: unread previous byte means the new one is lost
    if (done) begin
      events[EV_RXFULL] = 1'b1;
      if (next_rxFull) begin
        events[EV_OVERRUN] = 1'b1;
      end else begin
        next_rxBuf = doneByte;
        next_rxFull = 1'b1;
        next_cmpPending = 1'b1;
      end
    end
    if (cmpPending && rxBuf == compare) begin
      next_matchFlag = 1'b1;
      events[EV_MATCH] = 1'b1;
    end
    // a fault drops to slave and abandons the transfer
    if (faultHit) begin
      next_faultFlag = 1'b1;
      next_ctrl1[C1_MASTER] = 1'b0;
      next_state = ST_IDLE;
      next_bitCnt = 4'h0;
      next_sclkReg = 1'b0;
      events[EV_FAULT] = 1'b1;
    end
    // events win over a same-cycle clear
    next_irqStat = next_irqStat | events;
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl1 <= CTRL1_RST;
      ctrl2 <= CTRL2_RST;
      compare <= BYTE_RST;
      rxBuf <= BYTE_RST;
      txBuf <= BYTE_RST;
      shifter <= BYTE_RST;
      rdData <= BYTE_RST;
      divCnt <= BYTE_RST;
      irqStat <= EVENT_RST;
      irqMask <= EVENT_RST;
      bitCnt <= 4'h0;
      txFull <= 1'b0;
      rxFull <= 1'b0;
      matchFlag <= 1'b0;
      faultFlag <= 1'b0;
      cmpPending <= 1'b0;
      latchBit <= 1'b0;
      sclkReg <= 1'b0;
      armTx <= 1'b0;
      armRx <= 1'b0;
      armMatch <= 1'b0;
      armFault <= 1'b0;
      state <= ST_IDLE;
    end else begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      compare <= next_compare;
      rxBuf <= next_rxBuf;
      txBuf <= next_txBuf;
      shifter <= next_shifter;
      rdData <= next_rdData;
      divCnt <= next_divCnt;
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      bitCnt <= next_bitCnt;
      txFull <= next_txFull;
      rxFull <= next_rxFull;
      matchFlag <= next_matchFlag;
      faultFlag <= next_faultFlag;
      cmpPending <= next_cmpPending;
      latchBit <= next_latchBit;
      sclkReg <= next_sclkReg;
      armTx <= next_armTx;
      armRx <= next_armRx;
      armMatch <= next_armMatch;
      armFault <= next_armFault;
      state <= next_state;
    end
  end

  // ****************************************************
  // pins and interrupt
  // ****************************************************
  assign sclkOut = sclkReg;
  assign sclkOeN = ~master;
  assign mosiOut = shifter[7];
  assign mosiOeN = ~master;
  assign misoOut = shifter[7];
  assign misoOeN = master | ~ssLow;
  assign ssOut = (state == ST_IDLE);
  assign ssOeN = ~(master && faultEn && select_output_enable);
  assign irq = (|(irqStat & irqMask))
    | (matchFlag & ctrl2[C2_MATCH_IRQ])
    | (faultFlag & ctrl1[C1_IRQ_EN]);

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_status_low;
    rdStatus |=> rdData[3:0] == 4'h0;
  endproperty
  a_status_low: assert property (p_status_low)
    else $error("status low nibble not zero");
  property p_rx_set;
    done && !rxFull |=> rxFull;
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("receive-full not set on completion");
  property p_rx_hold;
    rxFull && !(rdDataPort && armRx) |=> rxFull;
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive-full cleared without sequence");
  property p_match_set;
    done && !rxFull && doneByte == compare && !wrStrobe |=> ##1 matchFlag;
  endproperty
  a_match_set: assert property (p_match_set)
    else $error("match flag missed");
  property p_match_hold;
    matchFlag && !(wrStatus && wrData[BIT_MATCH] && armMatch)
      |=> matchFlag;
  endproperty
  a_match_hold: assert property (p_match_hold)
    else $error("match cleared without sequence");
  property p_ignored_write;
    wrDataPort && !armTx && !txFull |=> !txFull && $stable(txBuf);
  endproperty
  a_ignored_write: assert property (p_ignored_write)
    else $error("unarmed data write accepted");
  property p_idle_load;
    accept && master && state == ST_IDLE && !faultHit
      |=> txFull ##1 (!txFull && shifter == $past(txBuf));
  endproperty
  a_idle_load: assert property (p_idle_load)
    else $error("idle load did not empty buffer in two cycles");
  property p_fault_cause;
    $rose(faultFlag) |-> $past(master && faultEn && !select_output_enable);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("mode fault set outside master detect mode");
  property p_overrun_keep;
    done && rxFull && !(rdDataPort && armRx) |=> $stable(rxBuf);
  endproperty
  a_overrun_keep: assert property (p_overrun_keep)
    else $error("overrun byte overwrote receive buffer");
  property p_match_irq;
    matchFlag && ctrl2[C2_MATCH_IRQ] |-> irq;
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("match interrupt missing");
  c_overrun: cover property (done && rxFull);
  c_fault: cover property (faultHit);
  c_match: cover property ($rose(matchFlag));
  c_queued: cover property (done && txFull && master);
endmodule
`default_nettype wire

// [dv/spi_far_model.sv]
// Purpose: far-side serial peer, slave to our master or master to our slave
// Assumes: idle-low clock, sample on rise, change on fall, msb first
// Notes: bench loads txQ and calls prime, send and select
`timescale 1ns/1ps
`default_nettype none
module spi_far_model (
  input wire logic sclk, // clock wire
  input wire logic mosi, // master-out wire
  input wire logic miso, // master-in wire
  output logic sclkDrv, // clock drive when we lead
  output logic mosiDrv, // master-out drive when we lead
  output logic misoDrv, // master-in drive when we follow
  output logic ssDrv // select drive, low selects
);
  logic [7:0] txQ[$];
  logic [7:0] rxQ[$];
  logic [7:0] sh, rx;
  logic lead;
  int n;
  initial begin
    sclkDrv = 1'b0;
    mosiDrv = 1'b0;
    misoDrv = 1'b1;
    ssDrv = 1'b1;
    sh = 8'h00;
    lead = 1'b0;
    n = 0;
  end
  // *****************
  // follower role
  // *****************
  // empty queue shows a toggling pattern, never a held last bit
  task automatic prime();
    sh = (txQ.size() > 0) ? txQ.pop_front() : ~sh;
    misoDrv = sh[7];
  endtask
  always @(posedge sclk) if (!lead) begin
    rx = {rx[6:0], mosi};
    n = n + 1;
    if (n == 8) begin
      rxQ.push_back(rx);
      n = 0;
    end
  end
  always @(negedge sclk) if (!lead) begin
    if (n == 0) begin
      prime();
    end else begin
      sh = {sh[6:0], 1'b0};
      misoDrv = sh[7];
    end
  end
  // *****************
  // leader role
  // *****************
  task automatic select(input logic v);
    ssDrv = v;
  endtask
  // 80 ns link period, phase unrelated to the bench clock
  task automatic send(input logic [7:0] b, output logic [7:0] r);
    lead = 1'b1;
    #3;
    ssDrv = 1'b0;
    mosiDrv = b[7];
    #80;
    for (int i = 0; i < 8; i++) begin
      sclkDrv = 1'b1;
      r = {r[6:0], miso};
      #40;
      sclkDrv = 1'b0;
      mosiDrv = (i < 7) ? b[6 - i] : ~b[0];
      #40;
    end
    ssDrv = 1'b1;
    lead = 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/tb_spi_status_data_match.sv]
// Purpose: self-checking bench for the serial status, data and match block
// Assumes: far peer model on the link wires, 100 MHz clk
// Notes: expected bytes come from a bench lfsr seeded at 45
`timescale 1ns/1ps
`default_nettype none
module tb_spi_status_data_match import spi_sdm_pkg::*; ;
  logic clk, rst_n, wrStrobe, rdStrobe, irq;
  logic [3:0] addr;
  logic [7:0] wrData, rdData, seed, got;
  logic sclkOut, sclkOeN, mosiOut, mosiOeN, misoOut, misoOeN, ssOut, ssOeN;
  logic farSclk, farMosi, farMiso, farSs;
  logic [7:0] v [10];
  int numErrors = 0;
  int totalChecks = 0;
  wire logic sclkW = sclkOeN ? farSclk : sclkOut;
  wire logic mosiW = mosiOeN ? farMosi : mosiOut;
  wire logic misoW = misoOeN ? farMiso : misoOut;
  wire logic ssW = ssOeN ? farSs : ssOut;
  spi_status_data_match spi_status_data_match_i (
    .clk, .rst_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .irq,
    .sclkIn(sclkW), .sclkOut, .sclkOeN, .mosiIn(mosiW), .mosiOut, .mosiOeN,
    .misoIn(misoW), .misoOut, .misoOeN, .ssIn(ssW), .ssOut, .ssOeN
  );
  spi_far_model spi_far_model_i (
    .sclk(sclkW), .mosi(mosiW), .miso(misoW), .sclkDrv(farSclk),
    .mosiDrv(farMosi), .misoDrv(farMiso), .ssDrv(farSs)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // *****************
  // helpers
  // *****************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkBit(input string nm, input logic e);
    #1;
    totalChecks++;
    if (irq !== e) begin
      numErrors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, irq);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [7:0] e,
                       input string nm);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    chk(nm, e, rdData);
  endtask
  // armed write: status read first, as software must
  task automatic xfer(input logic [7:0] b);
    rdChk(ADDR_STATUS, 8'h20, "status before load");
    wr(ADDR_DATA, b);
  endtask
  // rx full lands on the same edge as the 8th fall, match one later
  task automatic waitRx(input int cnt);
    int k;
    k = 0;
    while (spi_far_model_i.rxQ.size() < cnt && k < 2000) begin
      @(posedge clk);
      k++;
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    numErrors++;
    testDone();
  end
  // *****************
  // tests
  // *****************
  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    seed = 8'h2d;
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      v[i] = seed;
    end
    for (int i = 0; i < 4; i++) spi_far_model_i.txQ.push_back(v[i]);
    repeat (16) @(posedge clk);
    // primed after time zero so the peer's own start-up cannot undo it
    spi_far_model_i.prime();
    rst_n <= 1'b1;
    rdChk(ADDR_STATUS, 8'h20, "status after reset");
    chkBit("irq after reset", 1'b0);
    wr(ADDR_STATUS, 8'hff);
    rdChk(ADDR_STATUS, 8'h20, "status after write");
    rdChk(4'hf, 8'h00, "unmapped read");
    $display("test registers done");
    wr(ADDR_COMPARE, v[0]);
    wr(ADDR_CTRL2, 8'h80);
    wr(ADDR_CTRL1, 8'h10);
    xfer(v[4]);
    wr(ADDR_DATA, ~v[4]);
    rdChk(ADDR_STATUS, 8'h20, "empty after idle load");
    xfer(v[5]);
    rdChk(ADDR_STATUS, 8'h00, "buffer queued");
    waitRx(1);
    rdChk(ADDR_STATUS, 8'he0, "full match moved");
    chkBit("match irq", 1'b1);
    rdChk(ADDR_DATA, v[0], "data byte one");
    rdChk(ADDR_STATUS, 8'h60, "full cleared");
    wr(ADDR_STATUS, 8'h40);
    rdChk(ADDR_STATUS, 8'h20, "match cleared");
    chkBit("match irq gone", 1'b0);
    waitRx(2);
    chk("queued byte next", v[5], spi_far_model_i.rxQ[1]);
    rdChk(ADDR_DATA, v[1], "unarmed data read");
    rdChk(ADDR_STATUS, 8'ha0, "full kept");
    rdChk(ADDR_DATA, v[1], "data byte two");
    rdChk(ADDR_STATUS, 8'h20, "full cleared again");
    $display("test master transfer done");
    wr(ADDR_IRQ_STAT, 8'hff);
    wr(ADDR_IRQ_MASK, 8'h08);
    xfer(v[6]);
    waitRx(3);
    wr(ADDR_DATA, v[7]);
    rdChk(ADDR_STATUS, 8'ha0, "status before overrun");
    wr(ADDR_DATA, v[7]);
    waitRx(4);
    chkBit("overrun irq", 1'b1);
    rdChk(ADDR_IRQ_STAT, 8'h09, "event bits");
    rdChk(ADDR_STATUS, 8'ha0, "status after overrun");
    rdChk(ADDR_DATA, v[2], "older byte kept");
    wr(ADDR_IRQ_MASK, 8'h00);
    chkBit("masked irq", 1'b0);
    wr(ADDR_IRQ_MASK, 8'h08);
    chkBit("unmasked irq", 1'b1);
    wr(ADDR_IRQ_STAT, 8'h08);
    chkBit("cleared irq", 1'b0);
    $display("test overrun done");
    wr(ADDR_CTRL2, 8'h10);
    wr(ADDR_CTRL1, 8'h90);
    spi_far_model_i.select(1'b0);
    repeat (6) @(posedge clk);
    rdChk(ADDR_STATUS, 8'h30, "fault set");
    chkBit("fault irq", 1'b1);
    spi_far_model_i.select(1'b1);
    wr(ADDR_CTRL1, 8'h90);
    rdChk(ADDR_STATUS, 8'h20, "fault cleared");
    chkBit("fault irq gone", 1'b0);
    // select output on: pin is driven by us, a low peer must not fault
    wr(ADDR_CTRL1, 8'h92);
    #1;
    spi_far_model_i.select(1'b0);
    repeat (6) @(posedge clk);
    #1;
    chk("select out idle", 8'h01, {7'h00, ssW});
    rdChk(ADDR_STATUS, 8'h20, "no fault with select out");
    spi_far_model_i.select(1'b1);
    wr(ADDR_CTRL2, 8'h00);
    spi_far_model_i.select(1'b0);
    repeat (6) @(posedge clk);
    rdChk(ADDR_STATUS, 8'h20, "no fault when off");
    spi_far_model_i.select(1'b1);
    $display("test mode fault done");
    wr(ADDR_CTRL1, 8'h00);
    xfer(v[9]);
    spi_far_model_i.send(v[8], got);
    chk("slave sent byte", v[9], got);
    repeat (8) @(posedge clk);
    rdChk(ADDR_STATUS, 8'ha0, "slave full");
    rdChk(ADDR_DATA, v[8], "slave byte");
    for (int i = 0; i < 4; i++) begin
      chk("far rx", v[4 + i], spi_far_model_i.rxQ[i]);
    end
    chk("far rx count", 8'h04, 8'(spi_far_model_i.rxQ.size()));
    $display("test slave done");
    testDone();
  end
endmodule
`default_nettype wire
